/* File: supply_seq_trigger_margin_loop.sv */
// per-channel power-on trigger selection and closed-loop margining
`timescale 1ns/100ps
module supply_seq_trigger_margin_loop #(
  parameter int NUM_CH = supply_seq_pkg::NUM_CH,
  parameter int SAMPLE_CYCLES = supply_seq_pkg::SAMPLE_CYCLES,
  parameter int DELAY = supply_seq_pkg::DELAY_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire supply_seq_pkg::cmd_t cmd_in,
  output logic [31:0] cmd_rdata_out,
  output logic cmd_ack_out,
  input wire logic operation_on_in,
  input wire logic [1:0] control_input_pin_in,
  input wire logic [1:0] on_off_config_in,
  input wire logic [supply_seq_pkg::NUM_INPUTS-1:0] power_good_in,
  input wire logic [3:0] signature_in,
  input wire logic signature_valid_in,
  input wire logic [supply_seq_pkg::NUM_INPUTS-1:0] voltage_monitor_mask_in,
  input wire supply_seq_pkg::margin_req_t margin_request_in,
  input wire logic [NUM_CH-1:0][supply_seq_pkg::VOUT_W-1:0] vout_in,
  input wire logic [NUM_CH-1:0][supply_seq_pkg::VOUT_W-1:0] target_high_in,
  input wire logic [NUM_CH-1:0][supply_seq_pkg::VOUT_W-1:0] target_low_in,
  input wire logic [supply_seq_pkg::NUM_PWM-1:0][2:0] output_pin_function_config_in,
  output logic [NUM_CH-1:0] power_on_start_out,
  output logic [supply_seq_pkg::NUM_PWM-1:0] margin_pulse_out,
  output logic [supply_seq_pkg::NUM_PWM-1:0] margin_pulse_oe_out,
  output logic [NUM_CH-supply_seq_pkg::NUM_PWM-1:0][7:0] dac_setting_out,
  output logic [NUM_CH-supply_seq_pkg::NUM_PWM-1:0] dac_oe_out,
  output logic [NUM_CH-1:0] margin_fault_out
);
  localparam int NUM_DAC = NUM_CH - supply_seq_pkg::NUM_PWM;

  ////////////////////////////////////////////////////////////////////////////
  // configuration words, one pair per channel
  logic [NUM_CH-1:0][31:0] seq_cfg;
  logic [NUM_CH-1:0][15:0] margin_cfg;
  logic [NUM_CH-1:0][31:0] next_seq_cfg;
  logic [NUM_CH-1:0][15:0] next_margin_cfg;
  logic [31:0] next_rdata;
  logic next_ack;

  always_comb begin
    next_seq_cfg = seq_cfg;
    next_margin_cfg = margin_cfg;
    next_rdata = cmd_rdata_out;
    next_ack = 1'b0;
    if (cmd_in.valid) begin
      next_ack = 1'b1;
      next_rdata = 32'h0000_0000;
      if (int'(cmd_in.page) < NUM_CH) begin
        if (cmd_in.code == supply_seq_pkg::SEQ_CFG_CODE) begin
          // software is expected not to rewrite this while supplies run
          if (cmd_in.write) begin
            next_seq_cfg[cmd_in.page] = cmd_in.wdata & supply_seq_pkg::SEQ_CFG_MASK;
          end else begin
            next_rdata = seq_cfg[cmd_in.page];
          end
        end else if (cmd_in.code == supply_seq_pkg::MARGIN_CFG_CODE) begin
          if (cmd_in.write) begin
            next_margin_cfg[cmd_in.page] = cmd_in.wdata[15:0] & supply_seq_pkg::MARGIN_CFG_MASK;
          end else begin
            next_rdata = {16'h0000, margin_cfg[cmd_in.page]};
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seq_cfg <= {NUM_CH{supply_seq_pkg::SEQ_CFG_RESET}};
      margin_cfg <= {NUM_CH{supply_seq_pkg::MARGIN_CFG_RESET}};
      cmd_rdata_out <= 32'h0000_0000;
      cmd_ack_out <= 1'b0;
    end else begin
      seq_cfg <= next_seq_cfg;
      margin_cfg <= next_margin_cfg;
      cmd_rdata_out <= next_rdata;
      cmd_ack_out <= next_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence signal decode: each enabled term must agree
  logic seq_zero;
  logic seq_one;
  always_comb begin
    seq_zero = (operation_on_in | ~on_off_config_in[0]) & (control_input_pin_in[0] | ~on_off_config_in[1]);
    seq_one = (operation_on_in | ~on_off_config_in[0]) & (control_input_pin_in[1] | ~on_off_config_in[1]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm timebase shared by all pulse outputs
  logic [4:0] pwm_phase;
  logic [4:0] next_pwm_phase;
  always_comb begin
    next_pwm_phase = (pwm_phase == 5'(supply_seq_pkg::PWM_PERIOD - 1)) ? 5'h00 : pwm_phase + 5'h01;
  end
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwm_phase <= 5'h00;
    end else begin
      pwm_phase <= next_pwm_phase;
    end
  end

  logic all_monitored_good;
  always_comb begin
    all_monitored_good = &(power_good_in | ~voltage_monitor_mask_in);
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel trigger and margin loop
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic start_raw;
      logic [1:0] src;
      logic [3:0] match;
      logic [15:0] sel_mask;
      always_comb begin
        src = seq_cfg[ch][supply_seq_pkg::SRC_LO +: 2];
        match = seq_cfg[ch][supply_seq_pkg::MATCH_LO +: 4];
        sel_mask = seq_cfg[ch][supply_seq_pkg::MASK_LO +: 16];
        case (src)
          supply_seq_pkg::SRC_SEQUENCE: start_raw = seq_cfg[ch][supply_seq_pkg::SEL_SEQ_BIT] ? seq_one : seq_zero;
          supply_seq_pkg::SRC_COMBINE: start_raw = &(power_good_in | ~sel_mask);
          supply_seq_pkg::SRC_SIGNATURE: start_raw = (match != 4'h0) & signature_valid_in & (signature_in == match);
          default: start_raw = 1'b0;
        endcase
      end

      delay_filter #(.DELAY(DELAY)) u_delay (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .level_in(start_raw),
        .level_out(power_on_start_out[ch])
      );

      supply_seq_pkg::loop_t lp;
      supply_seq_pkg::loop_t next_lp;
      logic pin_is_pwm;
      logic [supply_seq_pkg::VOUT_W-1:0] target;
      logic [supply_seq_pkg::VOUT_W+1:0] sum;
      logic [supply_seq_pkg::VOUT_W-1:0] avg;
      logic raise;
      logic step_up;
      always_comb begin
        if (ch < supply_seq_pkg::NUM_PWM) begin
          pin_is_pwm = output_pin_function_config_in[ch % supply_seq_pkg::NUM_PWM] == supply_seq_pkg::PIN_FUNC_PWM;
        end else begin
          pin_is_pwm = 1'b1;
        end
        target = (margin_request_in == supply_seq_pkg::MARGIN_HIGH) ? target_high_in[ch] : target_low_in[ch];
        sum = lp.acc + {2'b00, vout_in[ch]};
        avg = sum[supply_seq_pkg::VOUT_W+1:2];
        raise = avg < target;
        step_up = raise == margin_cfg[ch][supply_seq_pkg::SLOPE_BIT];
        next_lp = lp;
        case (lp.state)
          supply_seq_pkg::M_IDLE: begin
            next_lp.fault = 1'b0;
            if (margin_request_in != supply_seq_pkg::MARGIN_NONE && pin_is_pwm) begin
              next_lp.state = supply_seq_pkg::M_WAIT_PG;
            end
          end
          supply_seq_pkg::M_WAIT_PG: begin
            if (all_monitored_good) begin
              next_lp.state = supply_seq_pkg::M_RUN;
              next_lp.setting = margin_cfg[ch][7:0];
              next_lp.acc = '0;
              next_lp.samples = 2'h0;
              next_lp.timer = 16'h0000;
            end
          end
          supply_seq_pkg::M_RUN: begin
            if (lp.timer == 16'(SAMPLE_CYCLES - 1)) begin
              next_lp.timer = 16'h0000;
              next_lp.acc = sum;
              next_lp.samples = lp.samples + 2'h1;
              if (lp.samples == 2'(supply_seq_pkg::AVG_SAMPLES - 1)) begin
                next_lp.acc = '0;
                if (margin_cfg[ch][supply_seq_pkg::OPEN_LOOP_BIT]) begin
                  next_lp.setting = margin_cfg[ch][7:0];
                end else if (avg != target) begin
                  if (step_up && lp.setting == supply_seq_pkg::SETTING_MAX) begin
                    next_lp.fault = 1'b1;
                  end else if (!step_up && lp.setting == supply_seq_pkg::SETTING_MIN) begin
                    next_lp.fault = 1'b1;
                  end else if (step_up) begin
                    next_lp.setting = lp.setting + 8'h01;
                  end else begin
                    next_lp.setting = lp.setting - 8'h01;
                  end
                end
              end
            end else begin
              next_lp.timer = lp.timer + 16'h0001;
            end
          end
          default: next_lp.state = supply_seq_pkg::M_IDLE;
        endcase
        if (margin_request_in == supply_seq_pkg::MARGIN_NONE || !pin_is_pwm) begin
          next_lp.state = supply_seq_pkg::M_IDLE;
          next_lp.fault = 1'b0;
        end
      end

      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          lp <= '0;
        end else begin
          lp <= next_lp;
        end
      end

      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          margin_fault_out[ch] <= 1'b0;
        end else begin
          margin_fault_out[ch] <= next_lp.fault;
        end
      end

      if (ch < supply_seq_pkg::NUM_PWM) begin : g_pwm
        always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
          if (!reset_n_in) begin
            margin_pulse_out[ch] <= 1'b0;
            margin_pulse_oe_out[ch] <= 1'b0;
          end else begin
            margin_pulse_out[ch] <= next_pwm_phase < next_lp.setting[7:3];
            margin_pulse_oe_out[ch] <= next_lp.state == supply_seq_pkg::M_RUN;
          end
        end
      end else begin : g_dac
        always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
          if (!reset_n_in) begin
            dac_setting_out[ch - supply_seq_pkg::NUM_PWM] <= 8'h00;
            dac_oe_out[ch - supply_seq_pkg::NUM_PWM] <= 1'b0;
          end else begin
            dac_setting_out[ch - supply_seq_pkg::NUM_PWM] <= next_lp.setting;
            dac_oe_out[ch - supply_seq_pkg::NUM_PWM] <= next_lp.state == supply_seq_pkg::M_RUN;
          end
        end
      end
    end
  endgenerate
endmodule

/* File: supply_seq_pkg.sv */
// constants, types and behaviour list for the sequencing trigger and margin loop
// Behaviour
// - an on/off delay changes output only after input stays steady the whole delay
// - bits 5:4 select the start source: sequence, input combination, signature, reserved
// - source 00 waits for sequence signal zero or one chosen by bit 0
// - sequence signals decode the operation state and control pins per on/off setting
// - source 01 starts when the AND of inputs selected by bits 31:16 holds
// - source 10 starts on signature equal to bits 11:8; zero disables matching
// - bits 15:12, 7:6 and 3:1 of the sequencing word read as zero
// - a pin set to any non-pwm function suppresses margining on that pin
// - channels 0-7 margin through own pwm, 8-11 through the external dac
// - margining pwm runs at a fixed 312.5 khz
// - pwm and dac outputs are high impedance while margining is inactive
// - margining starts only after every monitored channel passed power-good-on
// - each iteration averages four samples over 20 ms, then steps setting once
// - step direction comes from the average-below-target compare together with the slope bit
// - slope bit 15: 0 higher setting lowers voltage, 1 raises it
// - unreachable target at zero or full scale flags a fault, loop keeps running
package supply_seq_pkg;
  localparam int NUM_CH = 12;
  localparam int NUM_PWM = 8;
  localparam int NUM_INPUTS = 16;
  localparam int VOUT_W = 12;
  localparam logic [7:0] SEQ_CFG_CODE = 8'hE8;
  localparam logic [7:0] MARGIN_CFG_CODE = 8'hDF;
  localparam logic [31:0] SEQ_CFG_RESET = 32'h0000_0000;
  localparam logic [15:0] MARGIN_CFG_RESET = 16'h0000;
  localparam logic [31:0] SEQ_CFG_MASK = 32'hFFFF_0F31;
  localparam logic [15:0] MARGIN_CFG_MASK = 16'hC0FF;
  localparam int SEL_SEQ_BIT = 0;
  localparam int SRC_LO = 4;
  localparam int MATCH_LO = 8;
  localparam int MASK_LO = 16;
  localparam int SLOPE_BIT = 15;
  localparam int OPEN_LOOP_BIT = 14;
  localparam logic [1:0] SRC_SEQUENCE = 2'h0;
  localparam logic [1:0] SRC_COMBINE = 2'h1;
  localparam logic [1:0] SRC_SIGNATURE = 2'h2;
  localparam logic [2:0] PIN_FUNC_PWM = 3'h0;
  localparam logic [7:0] SETTING_MAX = 8'hFF;
  localparam logic [7:0] SETTING_MIN = 8'h00;
  localparam int CLK_KHZ = 10000;
  localparam int PWM_FREQ_HZ_X10 = 3125000;
  localparam int PWM_PERIOD = (CLK_KHZ * 10000) / PWM_FREQ_HZ_X10;
  localparam int AVG_TIME_US = 20000;
  localparam int AVG_SAMPLES = 4;
  localparam int SAMPLE_CYCLES = (AVG_TIME_US / AVG_SAMPLES) * (CLK_KHZ / 1000);
  localparam int DELAY_CYCLES = 16;

  typedef enum logic [1:0] {MARGIN_NONE, MARGIN_HIGH, MARGIN_LOW} margin_req_t;
  typedef enum logic [1:0] {M_IDLE, M_WAIT_PG, M_RUN} margin_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] page;
    logic [7:0] code;
    logic [31:0] wdata;
  } cmd_t;

  typedef struct packed {
    margin_state_t state;
    logic [7:0] setting;
    logic [VOUT_W+1:0] acc;
    logic [1:0] samples;
    logic [15:0] timer;
    logic fault;
  } loop_t;
endpackage

/* File: delay_filter.sv */
// steady-input delay filter for one start condition
`timescale 1ns/100ps
module delay_filter #(
  parameter int DELAY = supply_seq_pkg::DELAY_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic level_in,
  output logic level_out
);
  logic last;
  logic [15:0] count;
  logic next_last;
  logic [15:0] next_count;
  logic next_level;

  always_comb begin
    next_last = level_in;
    next_count = count;
    next_level = level_out;
    if (level_in != last || level_in == level_out) begin
      next_count = 16'h0000;
    end else if (count >= 16'(DELAY - 1)) begin
      next_level = level_in;
      next_count = 16'h0000;
    end else begin
      next_count = count + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last <= 1'b0;
      count <= 16'h0000;
      level_out <= 1'b0;
    end else begin
      last <= next_last;
      count <= next_count;
      level_out <= next_level;
    end
  end
endmodule

/* File: seq_margin_chk.sv */
// port-level checks for the trigger and margin block
`timescale 1ns/100ps
module seq_margin_chk #(
  parameter int NUM_CH = 12
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire supply_seq_pkg::cmd_t cmd_in,
  input wire logic [31:0] cmd_rdata_out,
  input wire logic cmd_ack_out,
  input wire logic [15:0] power_good_in,
  input wire logic [15:0] voltage_monitor_mask_in,
  input wire supply_seq_pkg::margin_req_t margin_request_in,
  input wire logic [7:0][2:0] output_pin_function_config_in,
  input wire logic [NUM_CH-1:0] power_on_start_out,
  input wire logic [7:0] margin_pulse_out,
  input wire logic [7:0] margin_pulse_oe_out,
  input wire logic [NUM_CH-9:0][7:0] dac_setting_out,
  input wire logic [NUM_CH-9:0] dac_oe_out,
  input wire logic [NUM_CH-1:0] margin_fault_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic [4:0] rise_cnt, next_rise_cnt;
  logic [7:0] chg_cnt, next_chg_cnt, dac_q;
  logic rise_seen, next_rise_seen, pulse_q, pg_ok_q, rise, oe_q;
  ////////////////////////////////////////////////////////////////
  // a pulse may start mid-period as the pin is enabled, so only a rise with the pin already driven arms the check
  always_comb begin
    rise = margin_pulse_out[0] && !pulse_q;
    next_rise_cnt = rise ? 5'h00 : rise_cnt + 5'h01;
    next_rise_seen = margin_pulse_oe_out[0] && (rise_seen || (rise && oe_q));
    next_chg_cnt = (dac_setting_out[0] != dac_q) ? 8'h00 : chg_cnt + {7'h00, chg_cnt != 8'hFF};
  end
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rise_cnt <= 5'h00;
      rise_seen <= 1'b0;
      chg_cnt <= 8'h00;
      pulse_q <= 1'b0;
      dac_q <= 8'h00;
      pg_ok_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= margin_pulse_oe_out[0];
      rise_cnt <= next_rise_cnt;
      rise_seen <= next_rise_seen;
      chg_cnt <= next_chg_cnt;
      pulse_q <= margin_pulse_out[0];
      dac_q <= dac_setting_out[0];
      pg_ok_q <= (power_good_in & voltage_monitor_mask_in) == voltage_monitor_mask_in;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_read(logic [7:0] code);
    cmd_in.valid && !cmd_in.write && cmd_in.code == code;
  endsequence
  sequence s_step;
    dac_oe_out[0] && $past(dac_oe_out[0]) && $changed(dac_setting_out[0]);
  endsequence
  AST_ACK: assert property (cmd_in.valid |=> cmd_ack_out) else $error("command not acknowledged");
  AST_ACK_ONLY: assert property (!cmd_in.valid |=> !cmd_ack_out) else $error("acknowledge without command");
  AST_SEQ_ZERO: assert property (s_read(supply_seq_pkg::SEQ_CFG_CODE) |=>
    (cmd_rdata_out & ~supply_seq_pkg::SEQ_CFG_MASK) == 32'h0000_0000) else $error("unused sequence bits set");
  AST_IDLE_FLOAT: assert property (margin_request_in == supply_seq_pkg::MARGIN_NONE |=>
    margin_pulse_oe_out == 8'h00 && dac_oe_out == '0 && margin_fault_out == '0) else $error("output driven idle");
  AST_PIN_FUNC: assert property (output_pin_function_config_in[1] != supply_seq_pkg::PIN_FUNC_PWM |=>
    !margin_pulse_oe_out[1]) else $error("pwm driven on other pin function");
  AST_PG_FIRST: assert property ($rose(dac_oe_out[0]) |-> pg_ok_q) else $error("margin before power good");
  AST_START_HOLD: assert property ($changed(power_on_start_out[0]) |=>
    $stable(power_on_start_out[0]) [*2]) else $error("start output changed too soon");
  AST_PWM_PERIOD: assert property ($rose(margin_pulse_out[0]) && rise_seen |->
    rise_cnt == 5'h1F) else $error("pwm period wrong");
  AST_ONE_STEP: assert property (s_step |-> chg_cnt >= 8'h0F &&
    (dac_setting_out[0] == $past(dac_setting_out[0]) + 8'h01 || dac_setting_out[0] == $past(dac_setting_out[0]) - 8'h01))
    else $error("setting step wrong");
  AST_FAULT_END: assert property ($rose(margin_fault_out[9]) |->
    dac_setting_out[1] == supply_seq_pkg::SETTING_MIN || dac_setting_out[1] == supply_seq_pkg::SETTING_MAX)
    else $error("fault away from end of scale");
endmodule
bind supply_seq_trigger_margin_loop seq_margin_chk #(.NUM_CH(NUM_CH)) chk (.sys_clk_in, .reset_n_in, .cmd_in,
  .cmd_rdata_out, .cmd_ack_out, .power_good_in, .voltage_monitor_mask_in, .margin_request_in,
  .output_pin_function_config_in, .power_on_start_out, .margin_pulse_out, .margin_pulse_oe_out,
  .dac_setting_out, .dac_oe_out, .margin_fault_out);

/* File: supply_model.sv */
// behavioural supplies answering the first two dac outputs
`timescale 1ns/100ps
module supply_model (
  input wire logic [3:0][7:0] dac_setting_in,
  input wire logic [3:0] dac_oe_in,
  output logic [11:0][11:0] vout_out
);
  // a floating dac sources no current, so the supply sits at nominal
  always_comb begin
    vout_out = {12{12'h800}};
    if (dac_oe_in[0]) begin
      vout_out[8] = 12'h880 - {4'h0, dac_setting_in[0]};
    end
    if (dac_oe_in[1]) begin
      vout_out[9] = 12'h780 + {4'h0, dac_setting_in[1]};
    end
  end
endmodule

/* File: testbench.sv */
// register, trigger and margin loop tests
`timescale 1ns/100ps
module testbench;
  logic sys_clk_in, reset_n_in, cmd_ack_out, operation_on_in, signature_valid_in;
  supply_seq_pkg::cmd_t cmd_in;
  supply_seq_pkg::margin_req_t margin_request_in;
  logic [31:0] cmd_rdata_out, rd;
  logic [1:0] control_input_pin_in, on_off_config_in;
  logic [15:0] power_good_in, mon_mask;
  logic [3:0] signature_in, dac_oe;
  logic [11:0][11:0] vout, target_high, target_low;
  logic [7:0][2:0] pin_func;
  logic [11:0] start, fault;
  logic [7:0] pulse, pulse_oe;
  logic [3:0][7:0] dac;
  int err_count, checked;
  localparam logic [15:0] PG_TAB [3] = '{16'h0001, 16'h0003, 16'hFFFC};
  localparam logic [3:0] SIG_TAB [3] = '{4'h5, 4'h5, 4'h0};
  localparam logic [3:0] EXP_TAB [3] = '{4'h2, 4'h1, 4'h0};
  supply_seq_trigger_margin_loop #(.SAMPLE_CYCLES(4), .DELAY(3)) uut (.sys_clk_in, .reset_n_in, .cmd_in,
    .cmd_rdata_out, .cmd_ack_out, .operation_on_in, .control_input_pin_in, .on_off_config_in, .power_good_in,
    .signature_in, .signature_valid_in, .voltage_monitor_mask_in(mon_mask), .margin_request_in, .vout_in(vout),
    .target_high_in(target_high), .target_low_in(target_low), .output_pin_function_config_in(pin_func),
    .power_on_start_out(start), .margin_pulse_out(pulse), .margin_pulse_oe_out(pulse_oe), .dac_setting_out(dac),
    .dac_oe_out(dac_oe), .margin_fault_out(fault));
  supply_model model (.dac_setting_in(dac), .dac_oe_in(dac_oe), .vout_out(vout));
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // one command pulse; read data is taken at the edge after the acknowledge rises
  task automatic access(input logic wr, input logic [3:0] page, input logic [7:0] code, input logic [31:0] wd);
    @(posedge sys_clk_in);
    cmd_in <= '{1'b1, wr, page, code, wd};
    @(posedge sys_clk_in);
    cmd_in <= '0;
    @(posedge sys_clk_in);
    rd = cmd_rdata_out;
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    err_count++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    cmd_in = '0;
    operation_on_in = 1'b0;
    control_input_pin_in = 2'h1;
    on_off_config_in = 2'h3;
    power_good_in = 16'h0000;
    signature_in = 4'h0;
    signature_valid_in = 1'b1;
    mon_mask = 16'h0001;
    margin_request_in = supply_seq_pkg::MARGIN_NONE;
    target_high = {12{12'h800}};
    target_low = {12{12'h800}};
    pin_func = '0;
    pin_func[1] = 3'h1;
    reset_n_in = 1'b0;
    cyc(10);
    reset_n_in <= 1'b1;
    access(1'b0, 4'h0, supply_seq_pkg::SEQ_CFG_CODE, 32'h0);
    check(rd, supply_seq_pkg::SEQ_CFG_RESET);
    access(1'b0, 4'h8, supply_seq_pkg::MARGIN_CFG_CODE, 32'h0);
    check(rd, {16'h0000, supply_seq_pkg::MARGIN_CFG_RESET});
    access(1'b1, 4'h6, supply_seq_pkg::SEQ_CFG_CODE, 32'hFFFF_FFFF);
    access(1'b0, 4'h6, supply_seq_pkg::SEQ_CFG_CODE, 32'h0);
    check(rd, 32'hFFFF_0F31);
    access(1'b1, 4'hA, supply_seq_pkg::MARGIN_CFG_CODE, 32'hFFFF_FFFF);
    access(1'b0, 4'hA, supply_seq_pkg::MARGIN_CFG_CODE, 32'h0);
    check(rd, 32'h0000_C0FF);
    access(1'b0, 4'hC, supply_seq_pkg::SEQ_CFG_CODE, 32'h0);
    check(rd, 32'h0);
    $display("test registers finished");
    access(1'b1, 4'h1, supply_seq_pkg::SEQ_CFG_CODE, 32'h0000_0001);
    access(1'b1, 4'h2, supply_seq_pkg::SEQ_CFG_CODE, 32'h0003_0010);
    access(1'b1, 4'h3, supply_seq_pkg::SEQ_CFG_CODE, 32'h0000_0520);
    access(1'b1, 4'h4, supply_seq_pkg::SEQ_CFG_CODE, 32'h0000_0020);
    access(1'b1, 4'h5, supply_seq_pkg::SEQ_CFG_CODE, 32'h0000_0030);
    operation_on_in <= 1'b1;
    cyc(2);
    operation_on_in <= 1'b0;
    cyc(8);
    check(start[0], 1'b0);
    operation_on_in <= 1'b1;
    cyc(8);
    check(start[1:0], 2'b01);
    check(start[6], 1'b0);
    control_input_pin_in <= 2'h2;
    cyc(8);
    check(start[1:0], 2'b10);
    on_off_config_in <= 2'h1;
    cyc(8);
    check(start[1:0], 2'b11);
    for (int i = 0; i < 3; i++) begin
      power_good_in <= PG_TAB[i];
      signature_in <= SIG_TAB[i];
      signature_valid_in <= (i != 1);
      cyc(8);
      check(start[5:2], EXP_TAB[i]);
    end
    $display("test start sources finished");
    power_good_in <= 16'h0000;
    access(1'b1, 4'h8, supply_seq_pkg::MARGIN_CFG_CODE, 32'h0000_0080);
    access(1'b1, 4'h9, supply_seq_pkg::MARGIN_CFG_CODE, 32'h0000_8080);
    access(1'b1, 4'h0, supply_seq_pkg::MARGIN_CFG_CODE, 32'h0000_0080);
    target_high[8] <= 12'h803;
    target_high[9] <= 12'h803;
    margin_request_in <= supply_seq_pkg::MARGIN_HIGH;
    cyc(40);
    check({pulse_oe, dac_oe}, 12'h000);
    power_good_in <= 16'hFFFF;
    cyc(100);
    check({pulse_oe[1:0], dac_oe[1:0]}, 4'h7);
    check({dac[1], dac[0]}, 16'h837D);
    check(fault[9:8], 2'b00);
    margin_request_in <= supply_seq_pkg::MARGIN_NONE;
    cyc(2);
    check({pulse_oe, dac_oe}, 12'h000);
    target_low[8] <= 12'h7FD;
    target_low[9] <= 12'h000;
    margin_request_in <= supply_seq_pkg::MARGIN_LOW;
    cyc(2300);
    check({dac[1], dac[0]}, 16'h0083);
    check(fault[9:8], 2'b10);
    margin_request_in <= supply_seq_pkg::MARGIN_NONE;
    cyc(2);
    check({fault, dac_oe}, 16'h0000);
    $display("test margin loop finished");
    test_done();
  end
endmodule
